// File: rtl/dsp_core_regs.vh
/*
  Constants for the fixed-point signal processor execution datapath:
  instruction field positions, function codes, status bit positions,
  reset values and timing. Assumes inclusion by dsp_op_datapath.v only.
*/
`ifndef DSP_CORE_REGS_VH
`define DSP_CORE_REGS_VH

`define INSN_W 23
`define OPC_HI 22
`define OPC_LO 21
`define PSEL_HI 20
`define PSEL_LO 19
`define FN_HI 18
`define FN_LO 15
`define ASL_BIT 14
`define DPL_HI 13
`define DPL_LO 12
`define DPH_HI 11
`define DPH_LO 9
`define RPDEC_BIT 8
`define SRC_HI 7
`define SRC_LO 4
`define DST_HI 3
`define DST_LO 0
`define ID_HI 21
`define ID_LO 6
`define NA_HI 12
`define NA_LO 4

`define OPC_OP 2'h0
`define OPC_RT 2'h1
`define OPC_LD 2'h3

`define PSEL_RAM 2'h0
`define PSEL_IDB 2'h1
`define PSEL_MH 2'h2
`define PSEL_ML 2'h3

`define FN_NOP 4'h0
`define FN_OR 4'h1
`define FN_AND 4'h2
`define FN_XOR 4'h3
`define FN_SUB 4'h4
`define FN_ADD 4'h5
`define FN_SBB 4'h6
`define FN_ADC 4'h7
`define FN_DEC 4'h8
`define FN_INC 4'h9
`define FN_CMP 4'ha
`define FN_SHR1 4'hb
`define FN_SHL1 4'hc
`define FN_SHL2 4'hd
`define FN_SHL4 4'he
`define FN_SWAP 4'hf

`define SRC_NONE 4'h0
`define SRC_ACC1 4'h1
`define SRC_ACC2 4'h2
`define SRC_TR 4'h3
`define SRC_DP 4'h4
`define SRC_RP 4'h5
`define SRC_SGN 4'h7
`define SRC_STAT 4'ha
`define SRC_K 4'hd
`define SRC_L 4'he
`define SRC_MEM 4'hf

`define DST_ACC1 4'h1
`define DST_ACC2 4'h2
`define DST_TR 4'h3
`define DST_DP 4'h4
`define DST_RP 4'h5
`define DST_STAT 4'h7
`define DST_K 4'ha
`define DST_L 4'hd
`define DST_MEM 4'hf

`define ST_HOSTREQ 15
`define ST_BYTEPH 10
`define ST_IE 7
`define ST_PROG_MASK 16'h7bff
`define ST_RESET 16'h0000

`define INT_VECTOR 9'h100
`define PHASES 2'h3
`define CYCLE_NS 240
`define CLK_NS 10
`define CYCLE_CLKS (`CYCLE_NS / `CLK_NS)
`define SAT_POS 16'h7fff
`define SAT_NEG 16'h8000

`endif

// File: rtl/dsp_op_datapath.v
/*
  Execution datapath of a 16-bit fixed-point signal processor: ALU, two
  accumulators with flags, saturation sign, multiplier, return stack,
  interrupt entry and multifunction/immediate/branch execution.
  Assumes a 23-bit instruction and RAM/ROM read data arrive combinationally
  from outside for the current address.
*/
// Overview of operation
// - Sixteen-operation 16-bit two's complement ALU
// - Per-accumulator flags refresh unless function is no-op or accumulator is transfer destination
// - Six flags; auxiliary pair tracks triple-add overflow
// - Sign register gives 8000 or 7fff saturation
// - Second accumulator never changes the sign register
// - Signed 16x16 product latched every cycle
// - Upper keeps sign plus 15; lower left-justified
// - Four-entry return address stack
// - Interrupt calls 100h and clears enable bit
// - Every 23-bit instruction completes in one cycle
// - Four internal phases per instruction cycle
// - Multiply first, transfer before ALU, bus operand
// - ALU suppressed when accumulator is transfer destination
// - Pointers update at cycle end; product next cycle
// - Opcode 00 plain, 01 returns at cycle end
// - Multifunction fields decoded at documented bit positions
// - Operand select: RAM, bus, upper, lower product
// - Function codes ordered no-op through byte swap
// - Logic ops clear overflows; 1-bit shifts set carry
// - Program-owned status bits loadable; host bits excluded
`include "dsp_core_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module dsp_op_datapath #(
  parameter PC_W = 9,
  parameter DP_W = 7,
  parameter RP_W = 9
) (
  input wire clk,
  input wire resetn,
  input wire int_req,
  input wire [`INSN_W-1:0] insn,
  input wire [15:0] ram_rdata,
  input wire [15:0] rom_rdata,
  input wire host_request_set,
  input wire host_request_clr,
  input wire byte_phase_in,
  output reg [PC_W-1:0] pc_ff,
  output reg [DP_W-1:0] ram_pointer_ff,
  output reg [RP_W-1:0] rom_pointer_ff,
  output reg ram_we_ff,
  output reg [15:0] ram_wdata_ff,
  output reg [DP_W-1:0] ram_waddr_ff,
  output reg [15:0] accumulator_first_ff,
  output reg [15:0] accumulator_second_ff,
  output reg [5:0] first_flags_ff,
  output reg [5:0] second_flags_ff,
  output reg [15:0] saturation_sign_register_ff,
  output reg [15:0] processor_status_control_ff,
  output reg [15:0] prod_hi_ff,
  output reg [15:0] prod_lo_ff,
  output reg cycle_end_ff
);
  // Flag vector order: {aux sign, sign, carry, zero, aux ovf, ovf}
  localparam F_S1 = 5;
  localparam F_S0 = 4;
  localparam F_C = 3;
  localparam F_Z = 2;
  localparam F_OV1 = 1;
  localparam F_OV0 = 0;

  reg [1:0] phase_ff;
  reg [1:0] int_sync_ff;
  reg int_meta_ff;
  reg [PC_W-1:0] stack_ff [0:3];
  reg [1:0] sp_ff;
  reg [15:0] tr_ff;
  reg [15:0] k_ff;
  reg [15:0] l_ff;

  // Four phases of the 8 MHz-style cycle; state commits on the last one
  wire cycle_end = (phase_ff == `PHASES);
  wire [1:0] opc = insn[`OPC_HI:`OPC_LO];
  wire is_op = (opc == `OPC_OP) || (opc == `OPC_RT);
  wire is_ld = (opc == `OPC_LD);
  wire is_br = (opc == 2'h2);
  wire [1:0] psel = insn[`PSEL_HI:`PSEL_LO];
  wire [3:0] fn = insn[`FN_HI:`FN_LO];
  wire asel = insn[`ASL_BIT];
  wire [1:0] dpl_mod = insn[`DPL_HI:`DPL_LO];
  wire [2:0] dph_mod = insn[`DPH_HI:`DPH_LO];
  wire rp_dec = insn[`RPDEC_BIT];
  wire [3:0] src = insn[`SRC_HI:`SRC_LO];
  wire [3:0] dst = is_op ? insn[`DST_HI:`DST_LO] : insn[`DST_HI:`DST_LO];
  wire [2:0] brch = insn[20:18];
  wire [PC_W-1:0] br_target = insn[`NA_HI:`NA_LO];

  reg [15:0] internal_data_bus;
  always @* begin
    if (is_ld) begin
      internal_data_bus = insn[`ID_HI:`ID_LO];
    end else begin
      case (src)
        `SRC_ACC1: internal_data_bus = accumulator_first_ff;
        `SRC_ACC2: internal_data_bus = accumulator_second_ff;
        `SRC_TR: internal_data_bus = tr_ff;
        `SRC_DP: internal_data_bus = {{(16-DP_W){1'b0}}, ram_pointer_ff};
        `SRC_RP: internal_data_bus = {{(16-RP_W){1'b0}}, rom_pointer_ff};
        `SRC_SGN: internal_data_bus = saturation_sign_register_ff;
        `SRC_STAT: internal_data_bus = processor_status_control_ff;
        `SRC_K: internal_data_bus = k_ff;
        `SRC_L: internal_data_bus = l_ff;
        `SRC_MEM: internal_data_bus = ram_rdata;
        4'h6: internal_data_bus = rom_rdata;
        default: internal_data_bus = 16'h0000;
      endcase
    end
  end

  // Operand select, bus value already settled by the transfer
  reg [15:0] operand;
  always @* begin
    case (psel)
      `PSEL_RAM: operand = ram_rdata;
      `PSEL_IDB: operand = internal_data_bus;
      `PSEL_MH: operand = prod_hi_ff;
      default: operand = prod_lo_ff;
    endcase
  end

  wire [15:0] acc_sel = asel ? accumulator_second_ff
                             : accumulator_first_ff;
  wire [5:0] flags_sel = asel ? second_flags_ff : first_flags_ff;
  wire cin = flags_sel[F_C];

  reg [16:0] sum;
  reg [15:0] res;
  reg arith;
  reg sub_op;
  reg logic_c;
  reg [15:0] opb;
  reg cbit;
  always @* begin
    sum = 17'h00000;
    res = 16'h0000;
    arith = 1'b0;
    sub_op = 1'b0;
    logic_c = 1'b0;
    opb = 16'h0000;
    cbit = 1'b0;
    case (fn)
      `FN_OR: res = acc_sel | operand;
      `FN_AND: res = acc_sel & operand;
      `FN_XOR: res = acc_sel ^ operand;
      `FN_SUB, `FN_SBB, `FN_DEC: begin
        arith = 1'b1;
        sub_op = 1'b1;
        opb = (fn == `FN_DEC) ? 16'h0001 : operand;
        cbit = (fn == `FN_SBB) ? cin : 1'b0;
        sum = {1'b0, acc_sel} - {1'b0, opb} - {16'h0000, cbit};
        res = sum[15:0];
      end
      `FN_ADD, `FN_ADC, `FN_INC: begin
        arith = 1'b1;
        opb = (fn == `FN_INC) ? 16'h0001 : operand;
        cbit = (fn == `FN_ADC) ? cin : 1'b0;
        sum = {1'b0, acc_sel} + {1'b0, opb} + {16'h0000, cbit};
        res = sum[15:0];
      end
      `FN_CMP: res = ~acc_sel;
      `FN_SHR1: begin
        res = {acc_sel[15], acc_sel[15:1]};
        logic_c = acc_sel[0];
      end
      `FN_SHL1: begin
        res = {acc_sel[14:0], 1'b0};
        logic_c = acc_sel[15];
      end
      `FN_SHL2: res = {acc_sel[13:0], 2'h0};
      `FN_SHL4: res = {acc_sel[11:0], 4'h0};
      `FN_SWAP: res = {acc_sel[7:0], acc_sel[15:8]};
      default: res = acc_sel;
    endcase
  end

  // Two's complement overflow of this step
  wire ovf_now = sub_op
    ? (acc_sel[15] != opb[15]) && (res[15] != acc_sel[15])
    : (acc_sel[15] == opb[15]) && (res[15] != acc_sel[15]);

  // Auxiliary pair: overflow count nets out over up to three steps, aux
  // overflow stays set while the running sum is out of range and aux
  // sign holds the true sign of the out-of-range value.
  reg [5:0] nxt_flags;
  always @* begin
    nxt_flags = flags_sel;
    nxt_flags[F_S0] = res[15];
    nxt_flags[F_Z] = (res == 16'h0000);
    if (arith) begin
      nxt_flags[F_C] = sum[16];
      nxt_flags[F_OV0] = ovf_now;
      if (ovf_now) begin
        // True sign of an overflowed add or subtract is the old acc sign
        if (flags_sel[F_OV1] && (flags_sel[F_S1] != acc_sel[15])) begin
          nxt_flags[F_OV1] = 1'b0;
          nxt_flags[F_S1] = res[15];
        end else begin
          nxt_flags[F_OV1] = 1'b1;
          nxt_flags[F_S1] = acc_sel[15];
        end
      end else if (!flags_sel[F_OV1]) begin
        nxt_flags[F_S1] = res[15];
      end
    end else begin
      // Aux sign left as the result sign where it is indefinite
      nxt_flags[F_C] = logic_c;
      nxt_flags[F_OV0] = 1'b0;
      nxt_flags[F_OV1] = 1'b0;
      nxt_flags[F_S1] = res[15];
    end
  end

  wire acc_is_dst = is_op && (dst == (asel ? `DST_ACC2 : `DST_ACC1));
  wire alu_go = is_op && (fn != `FN_NOP) && !acc_is_dst;

  wire signed [31:0] product = $signed(k_ff) * $signed(l_ff);

  wire int_take = int_sync_ff[1] && processor_status_control_ff[`ST_IE];
  wire do_call = is_br && (brch == 3'h5);
  wire do_ret = (opc == `OPC_RT);

  reg [DP_W-1:0] nxt_dp;
  always @* begin
    nxt_dp = ram_pointer_ff;
    case (dpl_mod)
      2'h1: nxt_dp[3:0] = ram_pointer_ff[3:0] + 4'h1;
      2'h2: nxt_dp[3:0] = ram_pointer_ff[3:0] - 4'h1;
      2'h3: nxt_dp[3:0] = 4'h0;
      default: nxt_dp[3:0] = ram_pointer_ff[3:0];
    endcase
    nxt_dp[6:4] = ram_pointer_ff[6:4] ^ dph_mod;
  end

  always @(posedge clk) begin
    if (!resetn) begin
      phase_ff <= 2'h0;
      cycle_end_ff <= 1'b0;
      int_meta_ff <= 1'b0;
      int_sync_ff <= 2'h0;
    end else begin
      phase_ff <= phase_ff + 2'h1;
      cycle_end_ff <= cycle_end;
      int_meta_ff <= int_req;
      int_sync_ff <= {int_sync_ff[0], int_meta_ff};
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      pc_ff <= {PC_W{1'b0}};
      sp_ff <= 2'h0;
      ram_pointer_ff <= {DP_W{1'b0}};
      rom_pointer_ff <= {RP_W{1'b0}};
      ram_we_ff <= 1'b0;
      ram_wdata_ff <= 16'h0000;
      ram_waddr_ff <= {DP_W{1'b0}};
      accumulator_first_ff <= 16'h0000;
      accumulator_second_ff <= 16'h0000;
      first_flags_ff <= 6'h00;
      second_flags_ff <= 6'h00;
      saturation_sign_register_ff <= `SAT_POS;
      processor_status_control_ff <= `ST_RESET;
      prod_hi_ff <= 16'h0000;
      prod_lo_ff <= 16'h0000;
      tr_ff <= 16'h0000;
      k_ff <= 16'h0000;
      l_ff <= 16'h0000;
    end else begin
      ram_we_ff <= 1'b0;
      if (cycle_end) begin
        // Product of the operands held this cycle, usable next
        prod_hi_ff <= product[30:15];
        prod_lo_ff <= {product[14:0], 1'b0};
        if (is_op || is_ld) begin
          case (dst)
            `DST_ACC1: accumulator_first_ff <= internal_data_bus;
            `DST_ACC2: accumulator_second_ff <= internal_data_bus;
            `DST_TR: tr_ff <= internal_data_bus;
            `DST_K: k_ff <= internal_data_bus;
            `DST_L: l_ff <= internal_data_bus;
            4'hb: begin
              k_ff <= internal_data_bus;
              l_ff <= rom_rdata;
            end
            `DST_MEM: begin
              ram_we_ff <= 1'b1;
              ram_wdata_ff <= internal_data_bus;
              ram_waddr_ff <= ram_pointer_ff;
            end
            `DST_STAT: begin
              processor_status_control_ff <=
                (internal_data_bus & `ST_PROG_MASK) |
                (processor_status_control_ff & ~`ST_PROG_MASK);
            end
            default: ;
          endcase
        end
        if (alu_go) begin
          if (asel) begin
            accumulator_second_ff <= res;
            second_flags_ff <= nxt_flags;
          end else begin
            accumulator_first_ff <= res;
            first_flags_ff <= nxt_flags;
            saturation_sign_register_ff <= nxt_flags[F_S1]
              ? `SAT_NEG : `SAT_POS;
          end
        end
        // Pointer moves after their old values fed this cycle's transfer
        if (is_op) begin
          ram_pointer_ff <= (dst == `DST_DP) ? internal_data_bus[DP_W-1:0]
                                             : nxt_dp;
          rom_pointer_ff <= (dst == `DST_RP) ? internal_data_bus[RP_W-1:0]
                          : rom_pointer_ff - {{(RP_W-1){1'b0}}, rp_dec};
        end else if (is_ld && dst == `DST_DP) begin
          ram_pointer_ff <= internal_data_bus[DP_W-1:0];
        end else if (is_ld && dst == `DST_RP) begin
          rom_pointer_ff <= internal_data_bus[RP_W-1:0];
        end
        // Program flow; the return is the last act of the cycle
        if (int_take) begin
          stack_ff[sp_ff] <= pc_ff;
          sp_ff <= sp_ff + 2'h1;
          pc_ff <= `INT_VECTOR;
          processor_status_control_ff[`ST_IE] <= 1'b0;
        end else if (do_ret) begin
          sp_ff <= sp_ff - 2'h1;
          pc_ff <= stack_ff[sp_ff - 2'h1];
        end else if (do_call) begin
          stack_ff[sp_ff] <= pc_ff + {{(PC_W-1){1'b0}}, 1'b1};
          sp_ff <= sp_ff + 2'h1;
          pc_ff <= br_target;
        end else if (is_br && brch == 3'h4) begin
          pc_ff <= br_target;
        end else begin
          pc_ff <= pc_ff + {{(PC_W-1){1'b0}}, 1'b1};
        end
      end
      // Host bits come last, so a status move never overwrites them
      if (host_request_set) begin
        processor_status_control_ff[`ST_HOSTREQ] <= 1'b1;
      end else if (host_request_clr) begin
        processor_status_control_ff[`ST_HOSTREQ] <= 1'b0;
      end
      processor_status_control_ff[`ST_BYTEPH] <= byte_phase_in;
    end
  end
endmodule // dsp_op_datapath

`default_nettype wire

// File: dv/dsp_op_datapath_sva.sv
/*
  Port-level assertions for dsp_op_datapath, bound to every instance.
  Assumes one clock, synchronous active-low reset, and cycle_end_ff
  pulsing once after each committed instruction.
*/
`timescale 1ns/1ps
`default_nettype none
module dsp_op_datapath_sva #(
  parameter PC_W = 9
) (
  input wire clk,
  input wire resetn,
  input wire int_req,
  input wire host_request_set,
  input wire ram_we_ff,
  input wire [PC_W-1:0] pc_ff,
  input wire [15:0] accumulator_first_ff,
  input wire [15:0] accumulator_second_ff,
  input wire [5:0] first_flags_ff,
  input wire [15:0] saturation_sign_register_ff,
  input wire [15:0] processor_status_control_ff,
  input wire [15:0] prod_hi_ff,
  input wire [15:0] prod_lo_ff,
  input wire cycle_end_ff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_sat_tracks_aux: assert property (
    cycle_end_ff |-> saturation_sign_register_ff ==
      (first_flags_ff[5] ? 16'h8000 : 16'h7fff))
    else $error("sign register does not follow aux sign");
  a_sat_only_first: assert property (
    $changed(saturation_sign_register_ff) |-> $changed(first_flags_ff))
    else $error("sign register moved without first flags");
  a_prod_lsb_zero: assert property (
    prod_lo_ff[0] == 1'b0)
    else $error("lower product lsb set");
  a_cycle_four: assert property (
    $rose(cycle_end_ff) |=> !cycle_end_ff [*3] ##1 cycle_end_ff)
    else $error("instruction cycle is not four clocks");
  a_commit_only: assert property (
    $changed({accumulator_first_ff, accumulator_second_ff, first_flags_ff,
      pc_ff, prod_hi_ff}) |-> cycle_end_ff)
    else $error("state changed away from commit");
  a_write_pulse: assert property (
    ram_we_ff |=> !ram_we_ff)
    else $error("ram write longer than one clock");
  a_int_taken: assert property (
    int_req && processor_status_control_ff[7] && cycle_end_ff
      |-> ##[1:12] (pc_ff == 9'h100))
    else $error("interrupt not vectored");
  a_int_disables: assert property (
    $rose(pc_ff == 9'h100) && int_req |-> !processor_status_control_ff[7])
    else $error("enable bit kept on interrupt entry");
  a_host_set: assert property (
    $rose(processor_status_control_ff[15])
      |-> $past(host_request_set) || $past(host_request_set, 2))
    else $error("host request bit set without request");
endmodule // dsp_op_datapath_sva

bind dsp_op_datapath dsp_op_datapath_sva #(.PC_W(PC_W)) u_sva (
  .clk(clk),
  .resetn(resetn),
  .int_req(int_req),
  .host_request_set(host_request_set),
  .ram_we_ff(ram_we_ff),
  .pc_ff(pc_ff),
  .accumulator_first_ff(accumulator_first_ff),
  .accumulator_second_ff(accumulator_second_ff),
  .first_flags_ff(first_flags_ff),
  .saturation_sign_register_ff(saturation_sign_register_ff),
  .processor_status_control_ff(processor_status_control_ff),
  .prod_hi_ff(prod_hi_ff),
  .prod_lo_ff(prod_lo_ff),
  .cycle_end_ff(cycle_end_ff)
);
`default_nettype wire

// File: dv/dsp_op_instruction_datapath_tb.sv
/*
  Self-checking bench for dsp_op_datapath: runs instruction words and
  checks registers after each commit.
  Assumes one commit per four clocks marked by cycle_end_ff; memory
  read data comes from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module dsp_op_instruction_datapath_tb;
  logic clk = 0;
  logic resetn = 0;
  logic int_req = 0;
  logic hset = 0;
  logic hclr = 0;
  logic bph = 0;
  logic [22:0] insn = 0;
  logic [15:0] rd = 0;
  wire [8:0] pc, rp;
  wire [6:0] dp, wa;
  wire [15:0] aa, ab, sat, st, ph, pl, wd;
  wire [5:0] fa, fb;
  wire we, ce;
  integer fails = 0;
  integer n_tests = 0;
  integer cyc = 0;
  integer i, s;
  logic [8:0] epc = 0;
  logic [8:0] ret [4];
  logic [63:0] t;
  logic [5:0] m;
  // fn, carry don't-care, accumulator, operand, result, flags
  logic [63:0] tab [18] = '{
    64'h1_0_00f0_0f00_0ff0_00, 64'h2_0_00f0_0f00_0000_04,
    64'h0_0_1234_0000_1234_04, 64'h3_0_ffff_00ff_ff00_30,
    64'h6_1_0005_0003_0002_00, 64'h4_1_0005_0003_0002_00,
    64'ha_0_00ff_0000_ff00_30, 64'h5_0_8000_8000_0000_2f,
    64'hc_0_8001_0000_0002_08, 64'h5_0_7fff_0001_8000_13,
    64'hb_0_0003_0000_0001_08, 64'h9_0_ffff_0000_0000_0c,
    64'h7_0_0001_0002_0004_00, 64'h8_1_0001_0000_0000_04,
    64'hd_0_0001_0000_0004_00, 64'he_0_0001_0000_0010_00,
    64'h4_1_8000_0001_7fff_23, 64'hf_0_1234_0000_3412_00};

  dsp_op_datapath dut (
    .clk(clk),
    .resetn(resetn),
    .int_req(int_req),
    .insn(insn),
    .ram_rdata(rd),
    .rom_rdata(16'h0000),
    .host_request_set(hset),
    .host_request_clr(hclr),
    .byte_phase_in(bph),
    .pc_ff(pc),
    .ram_pointer_ff(dp),
    .rom_pointer_ff(rp),
    .ram_we_ff(we),
    .ram_wdata_ff(wd),
    .ram_waddr_ff(wa),
    .accumulator_first_ff(aa),
    .accumulator_second_ff(ab),
    .first_flags_ff(fa),
    .second_flags_ff(fb),
    .saturation_sign_register_ff(sat),
    .processor_status_control_ff(st),
    .prod_hi_ff(ph),
    .prod_lo_ff(pl),
    .cycle_end_ff(ce)
  );

  function automatic [22:0] op(input [1:0] ps, input [3:0] fn,
    input a, input [5:0] pm, input [7:0] sd);
    op = {2'b00, ps, fn, a, pm, sd};
  endfunction

  // Move from RAM read data, so any 16-bit value reaches an accumulator, K or L; a status move loads only the 7bff bits
  function automatic [22:0] mv(input [3:0] dst);
    mv = {15'h0000, 4'hf, dst};
  endfunction

  task chk(input string nm, input [15:0] e, input [15:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Word is only sampled at the commit edge, so it may change any time
  task step(input [22:0] w, input [15:0] d);
    insn <= w;
    rd <= d;
    @(posedge clk);
    while (ce !== 1'b1)
      @(posedge clk);
  endtask

  task run(input [22:0] w, input [15:0] d);
    epc = epc + 1'b1;
    step(w, d);
    chk("pc", {7'h00, epc}, {7'h00, pc});
  endtask

  initial forever #5 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails = fails + 1;
      stop_test();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    chk("sat", 16'h7fff, sat);
    chk("st", 16'h0000, st);
    for (s = 0; s < 2; s++)
      for (i = 0; i < 18; i++) begin
        t = tab[i];
        m = t[56] ? 6'h37 : 6'h3f;
        run(mv(s ? 4'h2 : 4'h1), t[55:40]);
        run(op(2'b00, t[63:60], s[0], 6'h00, 8'h00), t[39:24]);
        chk("acc", t[23:8], s ? ab : aa);
        chk("flag", {10'h000, t[5:0] & m}, {10'h000, (s ? fb : fa) & m});
        chk("sat", (s == 0 && t[5]) ? 16'h8000 : 16'h7fff, sat);
      end
    $display("test alu done");
    run(mv(4'h1), 16'h8000);
    run(op(2'b00, 4'h5, 1'b0, 6'h00, 8'h72), 16'h8000);
    run(op(2'b00, 4'h0, 1'b0, 6'h00, 8'h71), 16'h0000);
    chk("sgn", 16'h8000, aa);
    chk("sgnb", 16'h7fff, ab);
    run(mv(4'ha), 16'hfffd);
    run(mv(4'hd), 16'h0005);
    run(op(2'b00, 4'h0, 1'b0, 6'h00, 8'h00), 16'h0000);
    chk("ph", 16'hffff, ph);
    chk("pl", 16'hffe2, pl);
    for (i = 0; i < 4; i++) begin
      run(mv(4'h1), 16'h0000);
      run(op(i[1:0], 4'h1, 1'b0, 6'h00, i == 1 ? 8'hf0 : 8'h00), 16'h0a0a);
      chk("opnd", i < 2 ? 16'h0a0a : (i == 2 ? 16'hffff : 16'hffe2), aa);
    end
    run(mv(4'ha), 16'h4000);
    run(mv(4'hd), 16'h4001);
    run(op(2'b00, 4'h0, 1'b0, 6'h00, 8'h00), 16'h0000);
    chk("ph", 16'h2000, ph);
    chk("pl", 16'h8000, pl);
    run(mv(4'h1), 16'h1000);
    run(op(2'b00, 4'h5, 1'b0, 6'h00, 8'hf1), 16'h0101);
    chk("supp", 16'h0101, aa);
    $display("test operand done");
    run(op(2'b00, 4'h0, 1'b0, 6'b011011, 8'h00), 16'h0000);
    chk("dp", 16'h0051, {9'h000, dp});
    chk("rp", 16'h01ff, {7'h00, rp});
    run(op(2'b00, 4'h0, 1'b0, 6'b110000, 8'h00), 16'h0000);
    chk("dp", 16'h0050, {9'h000, dp});
    run(op(2'b00, 4'h0, 1'b0, 6'b100000, 8'h00), 16'h0000);
    chk("dp", 16'h005f, {9'h000, dp});
    run(op(2'b00, 4'h0, 1'b0, 6'h00, 8'h1f), 16'h0000);
    chk("wd", 16'h0101, wd);
    chk("wa", 16'h005f, {9'h000, wa});
    chk("we", 16'h0001, {15'h0000, we});
    run({1'b1, 16'hc3c3, 2'b00, 4'h1}, 16'h0000);
    chk("ldi", 16'hc3c3, aa);
    chk("we", 16'h0000, {15'h0000, we});
    $display("test pointer done");
    for (i = 0; i < 4; i++) begin
      ret[i] = epc + 1'b1;
      epc = 9'h03f + {i[4:0], 4'h0};
      run({2'b10, 3'b101, 5'h00, epc + 1'b1, 4'h0}, 16'h0000);
    end
    for (i = 3; i >= 0; i--) begin
      epc = ret[i] - 1'b1;
      run(23'h200000, 16'h0000);
    end
    epc = 9'h0a4;
    run({2'b10, 3'b100, 5'h00, 9'h0a5, 4'h0}, 16'h0000);
    $display("test stack done");
    run(mv(4'h7), 16'hffff);
    chk("st", 16'h7bff, st);
    hset <= 1'b1;
    bph <= 1'b1;
    run(23'h000000, 16'h0000);
    chk("st", 16'hffff, st);
    hset <= 1'b0;
    hclr <= 1'b1;
    run(23'h000000, 16'h0000);
    hclr <= 1'b0;
    run(mv(4'h7), 16'h0000);
    chk("st", 16'h0400, st);
    $display("test status done");
    bph <= 1'b0;
    run(mv(4'h7), 16'h0080);
    int_req <= 1'b1;
    for (i = 0; i < 4 && pc !== 9'h100; i++)
      step(23'h000000, 16'h0000);
    chk("vec", 16'h0100, {7'h00, pc});
    chk("ie", 16'h0000, {15'h0000, st[7]});
    epc = 9'h100;
    // Request still high: enable is off, so no second entry
    for (i = 0; i < 3; i++)
      run(23'h000000, 16'h0000);
    int_req <= 1'b0;
    $display("test interrupt done");
    stop_test();
  end
endmodule // dsp_op_instruction_datapath_tb
`default_nettype wire
